// ### rtl/eip_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef EIP_DEFINES_SVH
`define EIP_DEFINES_SVH

// Byte addresses on the bus
`define EIP_ADDR_MCU_CONTROL 8'h00
`define EIP_ADDR_IRQ_ENABLE 8'h04
`define EIP_ADDR_IRQ_FLAGS 8'h08
`define EIP_ADDR_IRQ_STATUS 8'h0C
`define EIP_ADDR_IRQ_MASK 8'h10
`define EIP_ADDR_PIN_STATE 8'h14

// Reset values
`define EIP_RST_MCU_CONTROL 8'h00
`define EIP_RST_IRQ_ENABLE 8'h00
`define EIP_RST_IRQ_FLAGS 8'h00
`define EIP_RST_IRQ_STATUS 3'h0
`define EIP_RST_IRQ_MASK 3'h0

// Field positions
`define EIP_SENSE_A_LO 0
`define EIP_SENSE_A_HI 1
`define EIP_SENSE_B_LO 2
`define EIP_SENSE_B_HI 3
`define EIP_BIT_PIN_A 6
`define EIP_BIT_PIN_B 7
`define EIP_ST_PIN_A 0
`define EIP_ST_PIN_B 1
`define EIP_ST_WAKE 2

// Sense encodings
`define EIP_SENSE_LOW 2'h0
`define EIP_SENSE_ANY 2'h1
`define EIP_SENSE_FALL 2'h2
`define EIP_SENSE_RISE 2'h3

// Start-up time after a level wake
`define EIP_CLK_MHZ 20
`define EIP_STARTUP_NS 64000
`define EIP_STARTUP_CYC ((`EIP_STARTUP_NS * `EIP_CLK_MHZ + 999) / 1000)
`define EIP_STARTUP_W 11

`endif

// ### rtl/eip_pkg.sv
// Types shared by the external pin interrupt block
package eip_pkg;
   typedef logic [1:0] eip_sense_type;
   typedef enum logic [1:0] {WK_IDLE, WK_ONE, WK_START} eip_wake_type;
endpackage

// ### rtl/eip_sense.sv
// One pin: two-stage synchroniser and edge or change detector
`timescale 1ns/100ps
`include "eip_defines.svh"
module eip_sense (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Pin and setup
   input wire logic pin,
   input wire eip_pkg::eip_sense_type sense,
   input wire logic detect_en,
   // Results
   output logic pin_lvl,
   output logic edge_hit
);
   import eip_pkg::*;

   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         sync1_reg <= pin;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   wire rise = sync2_reg & ~prev_reg;
   wire fall = ~sync2_reg & prev_reg;
   wire any_hit = (sense == `EIP_SENSE_ANY) & (rise | fall);
   wire fall_hit = (sense == `EIP_SENSE_FALL) & fall;
   wire rise_hit = (sense == `EIP_SENSE_RISE) & rise;

   assign pin_lvl = sync2_reg;
   // Edges count only while the I/O clock runs
   assign edge_hit = detect_en & (any_hit | fall_hit | rise_hit);
endmodule

// ### rtl/eip_ext_irq.sv
// External pin interrupt block with AHB-Lite register slave
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
`include "eip_defines.svh"
// Functional notes
// - Pin activity raises requests even while the pin is driven as output.
// - In low-level mode the request stands while the pin is low and no wake is running.
// - Edges are seen only with the I/O clock running; level wakes sleep.
// - A level wake is sampled twice on watchdog ticks before waking.
// - A wake whose level vanishes before start-up ends gives no request.
// - Pin b sense is control bits 3:2: low, change, falling, rising.
// - Pin a sense is control bits 1:0 with the same encoding.
// - Pins are sampled before edge detection; pulses over a clock count.
// - A pin request needs its enable bit (b 7, a 6) and the global enable.
// - An event sets the pin's flag (b bit 7, a bit 6) to be vectored.
// - A flag clears on vector service or a one written to it.
// - In low-level mode the pin's flag always reads as cleared.
module eip_ext_irq (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // External pins, read from the pad
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   // Core side
   input wire logic core_glob_en,
   input wire logic vec_ack_a,
   input wire logic vec_ack_b,
   input wire logic io_clk_run,
   input wire logic sleep_pd,
   input wire logic wd_sample,
   output logic irq_req_a,
   output logic irq_req_b,
   output logic wake_req,
   output logic irq_out
);
   import eip_pkg::*;

   logic [7:0] mcu_control_reg;
   logic [7:0] mcu_control_next;
   logic [7:0] ext_irq_enable_reg;
   logic [7:0] ext_irq_enable_next;
   logic req_flag_a_reg;
   logic req_flag_a_next;
   logic req_flag_b_reg;
   logic req_flag_b_next;
   logic [2:0] irq_status_reg;
   logic [2:0] irq_status_next;
   logic [2:0] irq_mask_reg;
   logic [2:0] irq_mask_next;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   logic irq_req_a_reg;
   logic irq_req_b_reg;
   logic irq_out_reg;
   logic wake_req_reg;
   logic wake_int_reg;
   eip_wake_type wake_state_reg;
   eip_wake_type wake_state_next;
   logic [`EIP_STARTUP_W-1:0] start_cnt_reg;
   logic [`EIP_STARTUP_W-1:0] start_cnt_next;
   logic pin_lvl_a;
   logic pin_lvl_b;
   logic hit_a;
   logic hit_b;

   // Bus address phase
   wire addr_take = hsel & htrans[1] & hready;
   wire [7:0] a_off = haddr[7:0];
   wire a_low = haddr[31:8] == 24'h000000;
   wire sel_mcu = a_low & (a_off == `EIP_ADDR_MCU_CONTROL);
   wire sel_en = a_low & (a_off == `EIP_ADDR_IRQ_ENABLE);
   wire sel_flags = a_low & (a_off == `EIP_ADDR_IRQ_FLAGS);
   wire sel_stat = a_low & (a_off == `EIP_ADDR_IRQ_STATUS);
   wire sel_mask = a_low & (a_off == `EIP_ADDR_IRQ_MASK);
   wire sel_pins = a_low & (a_off == `EIP_ADDR_PIN_STATE);

   // Writes land in the data phase, when hwdata stands
   wire [7:0] wd = hwdata[7:0];
   wire wr_mcu = wr_pend_reg & (wr_addr_reg == `EIP_ADDR_MCU_CONTROL);
   wire wr_en = wr_pend_reg & (wr_addr_reg == `EIP_ADDR_IRQ_ENABLE);
   wire wr_flags = wr_pend_reg & (wr_addr_reg == `EIP_ADDR_IRQ_FLAGS);
   wire wr_stat = wr_pend_reg & (wr_addr_reg == `EIP_ADDR_IRQ_STATUS);
   wire wr_mask = wr_pend_reg & (wr_addr_reg == `EIP_ADDR_IRQ_MASK);

   // Sense and enable fields
   wire [1:0] sense_a = {mcu_control_reg[`EIP_SENSE_A_HI],
                         mcu_control_reg[`EIP_SENSE_A_LO]};
   wire [1:0] sense_b = {mcu_control_reg[`EIP_SENSE_B_HI],
                         mcu_control_reg[`EIP_SENSE_B_LO]};
   wire lvl_mode_a = sense_a == `EIP_SENSE_LOW;
   wire lvl_mode_b = sense_b == `EIP_SENSE_LOW;
   wire en_a = ext_irq_enable_reg[`EIP_BIT_PIN_A];
   wire en_b = ext_irq_enable_reg[`EIP_BIT_PIN_B];

   // Pin direction is never looked at, so driving the pin as an output
   // still raises requests: this is the software interrupt path.
   eip_sense u_sense_a (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin(ext_irq_pin_a),
      .sense(sense_a),
      .detect_en(io_clk_run),
      .pin_lvl(pin_lvl_a),
      .edge_hit(hit_a)
   );

   eip_sense u_sense_b (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin(ext_irq_pin_b),
      .sense(sense_b),
      .detect_en(io_clk_run),
      .pin_lvl(pin_lvl_b),
      .edge_hit(hit_b)
   );

   // Request flags: set wins over clear, forced low in level mode
   wire clr_a = (wr_flags & wd[`EIP_BIT_PIN_A]) | vec_ack_a;
   wire clr_b = (wr_flags & wd[`EIP_BIT_PIN_B]) | vec_ack_b;
   assign req_flag_a_next = ~lvl_mode_a
                            & ((req_flag_a_reg & ~clr_a) | hit_a);
   assign req_flag_b_next = ~lvl_mode_b
                            & ((req_flag_b_reg & ~clr_b) | hit_b);
   wire [7:0] flags_rd = {req_flag_b_reg, req_flag_a_reg, 6'h00};

   // Level wake: two watchdog samples, then the start-up wait
   wire low_a = en_a & lvl_mode_a & ~pin_lvl_a;
   wire low_b = en_b & lvl_mode_b & ~pin_lvl_b;
   wire wake_cand = low_a | low_b;
   wire wake_idle = wake_state_reg == WK_IDLE;
   wire start_last = start_cnt_reg ==
                     `EIP_STARTUP_W'(`EIP_STARTUP_CYC - 1);
   wire wake_int_hit = (wake_state_reg == WK_START) & start_last
                       & wake_cand;

   always_comb begin
      wake_state_next = wake_state_reg;
      start_cnt_next = start_cnt_reg;
      case (wake_state_reg)
         WK_IDLE: begin
            if (sleep_pd & wake_cand & wd_sample) begin
               wake_state_next = WK_ONE;
            end
         end
         WK_ONE: begin
            if (!sleep_pd) begin
               wake_state_next = WK_IDLE;
            end else if (wd_sample) begin
               wake_state_next = wake_cand ? WK_START : WK_IDLE;
               start_cnt_next = '0;
            end
         end
         WK_START: begin
            start_cnt_next = start_cnt_reg + `EIP_STARTUP_W'(1);
            if (start_last) begin
               wake_state_next = WK_IDLE;
            end
         end
         default: begin
            wake_state_next = WK_IDLE;
         end
      endcase
   end

   // Level requests carry the pin state directly and are held back
   // during a wake so that a level that vanishes gives no request.
   wire lvl_req_a = low_a & wake_idle;
   wire lvl_req_b = low_b & wake_idle;
   wire req_a_comb = core_glob_en & en_a
                     & (lvl_req_a | req_flag_a_reg);
   wire req_b_comb = core_glob_en & en_b
                     & (lvl_req_b | req_flag_b_reg);

   // Sticky status, write one to clear, set wins
   wire [2:0] st_set = {wake_int_hit, hit_b, hit_a};
   assign irq_status_next = (irq_status_reg & ~(wr_stat ? wd[2:0] : 3'h0))
                            | st_set;
   assign irq_mask_next = wr_mask ? wd[2:0] : irq_mask_reg;
   assign mcu_control_next = wr_mcu ? wd : mcu_control_reg;
   assign ext_irq_enable_next = wr_en ? {wd[7:6], 6'h00}
                                      : ext_irq_enable_reg;

   // Read data are picked in the address phase and held one cycle
   wire [7:0] pins_rd = {5'h00, wake_req_reg, pin_lvl_b, pin_lvl_a};
   wire [7:0] rd_byte = sel_mcu ? mcu_control_reg :
                        sel_en ? ext_irq_enable_reg :
                        sel_flags ? flags_rd :
                        sel_stat ? {5'h00, irq_status_reg} :
                        sel_mask ? {5'h00, irq_mask_reg} :
                        sel_pins ? pins_rd : 8'h00;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h00000000;
      end else begin
         wr_pend_reg <= addr_take & hwrite & (sel_mcu | sel_en | sel_flags
                        | sel_stat | sel_mask);
         wr_addr_reg <= a_off;
         hrdata_reg <= (addr_take & ~hwrite) ? {24'h000000, rd_byte}
                                              : 32'h00000000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mcu_control_reg <= `EIP_RST_MCU_CONTROL;
         ext_irq_enable_reg <= `EIP_RST_IRQ_ENABLE;
         req_flag_a_reg <= 1'b0;
         req_flag_b_reg <= 1'b0;
         irq_status_reg <= `EIP_RST_IRQ_STATUS;
         irq_mask_reg <= `EIP_RST_IRQ_MASK;
      end else begin
         mcu_control_reg <= mcu_control_next;
         ext_irq_enable_reg <= ext_irq_enable_next;
         req_flag_a_reg <= req_flag_a_next;
         req_flag_b_reg <= req_flag_b_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wake_state_reg <= WK_IDLE;
         start_cnt_reg <= '0;
         wake_req_reg <= 1'b0;
         wake_int_reg <= 1'b0;
      end else begin
         wake_state_reg <= wake_state_next;
         start_cnt_reg <= start_cnt_next;
         wake_req_reg <= wake_state_next == WK_START;
         wake_int_reg <= wake_int_hit;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irq_req_a_reg <= 1'b0;
         irq_req_b_reg <= 1'b0;
         irq_out_reg <= 1'b0;
      end else begin
         irq_req_a_reg <= req_a_comb;
         irq_req_b_reg <= req_b_comb;
         irq_out_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign irq_req_a = irq_req_a_reg;
   assign irq_req_b = irq_req_b_reg;
   assign wake_req = wake_req_reg;
   assign irq_out = irq_out_reg;

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   a_flag_level_zero: assert property (
      lvl_mode_a |=> !req_flag_a_reg)
      else $error("pin a flag set in low-level mode");

   a_req_needs_enables: assert property (
      irq_req_a_reg |-> $past(core_glob_en) && $past(en_a))
      else $error("pin a request without enables");

   a_level_holds_req: assert property (
      (core_glob_en && low_a && wake_idle)[*2] |=> irq_req_a_reg)
      else $error("level request dropped while pin low");

   a_edge_sets_flag: assert property (
      (hit_b && !lvl_mode_b) |=> req_flag_b_reg)
      else $error("pin b event did not set its flag");

   a_ack_clears_flag: assert property (
      (vec_ack_a && !hit_a && !lvl_mode_a) |=> !req_flag_a_reg)
      else $error("pin a flag survived service");

   a_w1c_clears_flag: assert property (
      (wr_flags && wd[`EIP_BIT_PIN_B] && !hit_b) |=> !req_flag_b_reg)
      else $error("pin b flag survived write one");

   a_stopped_no_edge: assert property (
      !io_clk_run |-> !hit_a && !hit_b)
      else $error("edge seen with I/O clock halted");

   a_rise_detect: assert property (
      (sense_a == `EIP_SENSE_RISE && io_clk_run && $rose(pin_lvl_a))
      |-> hit_a)
      else $error("pin a rising edge missed");

   a_wake_two_samples: assert property (
      $rose(wake_req_reg) |-> $past(wake_state_reg) == WK_ONE)
      else $error("wake without second sample");

   a_vanished_no_int: assert property (
      (wake_state_reg == WK_START && start_last && !wake_cand)
      |=> !wake_int_reg)
      else $error("interrupt after vanished wake level");

   a_irq_out_level: assert property (
      (|(irq_status_reg & irq_mask_reg)) |=> irq_out_reg)
      else $error("unmasked status did not raise irq_out");

   a_req_b_enables: assert property (
      irq_req_b_reg |-> $past(core_glob_en) && $past(en_b))
      else $error("pin b request without enables");

   a_fall_detect_b: assert property (
      (sense_b == `EIP_SENSE_FALL && io_clk_run && $fell(pin_lvl_b))
      |-> hit_b)
      else $error("pin b falling edge missed");

   a_change_detect: assert property (
      (sense_a == `EIP_SENSE_ANY && io_clk_run && $changed(pin_lvl_a))
      |-> hit_a)
      else $error("pin a change missed");

   a_flag_b_level: assert property (
      lvl_mode_b |=> !req_flag_b_reg)
      else $error("pin b flag set in low-level mode");

   c_edge_request: cover property (hit_a ##1 irq_req_a_reg);
   c_level_request: cover property (lvl_req_b ##1 irq_req_b_reg);
   c_wake_with_int: cover property (wake_int_hit);
   c_wake_no_int: cover property (
      wake_state_reg == WK_START && start_last && !wake_cand);
endmodule

// ### tb/eip_core_model.sv
// Core-side model that services pin requests with vector pulses
`timescale 1ns/100ps
module eip_core_model (
   // Clock
   input wire logic core_clk,
   // Requests and service setup
   input wire logic irq_req_a,
   input wire logic irq_req_b,
   input wire logic auto_ack,
   input wire logic [3:0] ack_lat,
   // Vector service pulses
   output logic vec_ack_a = 1'b0,
   output logic vec_ack_b = 1'b0
);
   // Latency lets the core answer promptly or slowly
   always begin
      @(posedge core_clk);
      if (auto_ack && irq_req_a === 1'b1) begin
         repeat (ack_lat) @(posedge core_clk);
         vec_ack_a <= 1'b1;
         @(posedge core_clk);
         vec_ack_a <= 1'b0;
         // Let the served request fall before looking again
         @(posedge core_clk);
      end
   end
   always begin
      @(posedge core_clk);
      if (auto_ack && irq_req_b === 1'b1) begin
         repeat (ack_lat) @(posedge core_clk);
         vec_ack_b <= 1'b1;
         @(posedge core_clk);
         vec_ack_b <= 1'b0;
         @(posedge core_clk);
      end
   end
endmodule

// ### tb/eip_ext_irq_tb.sv
// Self-checking bench for the external pin interrupt block
`timescale 1ns/100ps
`include "eip_defines.svh"
module eip_ext_irq_tb;
   localparam logic [7:0] ad_ctl = `EIP_ADDR_MCU_CONTROL;
   localparam logic [7:0] ad_en = `EIP_ADDR_IRQ_ENABLE;
   localparam logic [7:0] ad_fl = `EIP_ADDR_IRQ_FLAGS;
   localparam logic [7:0] ad_st = `EIP_ADDR_IRQ_STATUS;
   localparam logic [7:0] ad_mk = `EIP_ADDR_IRQ_MASK;
   localparam logic [7:0] ad_ps = `EIP_ADDR_PIN_STATE;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout;
   logic hresp;
   logic ext_irq_pin_a = 1'b1;
   logic ext_irq_pin_b = 1'b1;
   logic core_glob_en = 1'b0;
   logic io_clk_run = 1'b1;
   logic sleep_pd = 1'b0;
   logic wd_sample = 1'b0;
   logic auto_ack = 1'b0;
   logic [3:0] ack_lat = 4'h3;
   logic vec_ack_a;
   logic vec_ack_b;
   logic irq_req_a;
   logic irq_req_b;
   logic wake_req;
   logic irq_out;
   int err_total = 0;
   int tests_run = 0;

   eip_ext_irq DUT (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ext_irq_pin_a(ext_irq_pin_a),
      .ext_irq_pin_b(ext_irq_pin_b), .core_glob_en(core_glob_en),
      .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b),
      .io_clk_run(io_clk_run), .sleep_pd(sleep_pd),
      .wd_sample(wd_sample), .irq_req_a(irq_req_a),
      .irq_req_b(irq_req_b), .wake_req(wake_req), .irq_out(irq_out));
   eip_core_model u_core (.core_clk(core_clk), .irq_req_a(irq_req_a),
      .irq_req_b(irq_req_b), .auto_ack(auto_ack), .ack_lat(ack_lat),
      .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b));

   initial begin
      forever #25 core_clk = ~core_clk;
   end

   task results;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // One single transfer; read data taken at the data phase edge
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
   endtask

   task rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(nm, rd, {24'h0, exp});
   endtask

   task drv(input logic a, input logic b);
      @(posedge core_clk);
      ext_irq_pin_a <= a;
      ext_irq_pin_b <= b;
   endtask

   task wd;
      @(posedge core_clk);
      wd_sample <= 1'b1;
      @(posedge core_clk);
      wd_sample <= 1'b0;
   endtask

   task t_regs;
      rdc("control reset", ad_ctl, 8'h00);
      rdc("enable reset", ad_en, 8'h00);
      rdc("flags reset", ad_fl, 8'h00);
      rdc("status reset", ad_st, 8'h00);
      rdc("pin state idle", ad_ps, 8'h03);
      chk("hresp okay", {31'h0, hresp}, 32'h0);
      bus(1'b1, ad_mk, 8'hFF);
      rdc("mask rw", ad_mk, 8'h07);
      bus(1'b1, ad_ctl, 8'hA5);
      rdc("control rw", ad_ctl, 8'hA5);
      bus(1'b1, ad_en, 8'hFF);
      rdc("enable rw", ad_en, 8'hC0);
      bus(1'b1, 8'h18, 8'hFF);
      rdc("unmapped", 8'h18, 8'h00);
      $display("test regs done");
   endtask

   // Pin b takes every edge mode, pin a the same modes in reverse order
   task t_edges;
      logic [1:0] ma;
      logic [1:0] mb;
      bus(1'b1, ad_en, 8'h00);
      for (int i = 1; i < 4; i++) begin
         mb = i[1:0];
         ma = 2'(4 - i);
         bus(1'b1, ad_ctl, {4'h0, mb, ma});
         bus(1'b1, ad_fl, 8'hC0);
         drv(1'b0, 1'b0);
         cyc(6);
         rdc("fall flags", ad_fl, {mb != 2'h3, ma != 2'h3, 6'h0});
         bus(1'b1, ad_fl, 8'hC0);
         drv(1'b1, 1'b1);
         cyc(6);
         rdc("rise flags", ad_fl, {mb != 2'h2, ma != 2'h2, 6'h0});
         bus(1'b1, ad_fl, 8'hC0);
      end
      rdc("edge status", ad_st, 8'h03);
      // Edges made while the I/O clock is stopped go unseen
      @(posedge core_clk);
      io_clk_run <= 1'b0;
      drv(1'b0, 1'b0);
      cyc(6);
      drv(1'b1, 1'b1);
      cyc(6);
      rdc("io stopped", ad_fl, 8'h00);
      @(posedge core_clk);
      io_clk_run <= 1'b1;
      cyc(4);
      bus(1'b1, ad_fl, 8'hC0);
      $display("test edges done");
   endtask

   task t_req;
      bus(1'b1, ad_st, 8'h07);
      bus(1'b1, ad_ctl, 8'h03);
      bus(1'b1, ad_en, 8'h40);
      bus(1'b1, ad_mk, 8'h01);
      drv(1'b0, 1'b1);
      cyc(6);
      drv(1'b1, 1'b1);
      cyc(3);
      chk("sync delay", {31'h0, irq_out}, 32'h0);
      cyc(4);
      chk("no global", {31'h0, irq_req_a}, 32'h0);
      chk("irq out set", {31'h0, irq_out}, 32'h1);
      rdc("flag set", ad_fl, 8'h40);
      @(posedge core_clk);
      core_glob_en <= 1'b1;
      cyc(3);
      chk("req global", {31'h0, irq_req_a}, 32'h1);
      bus(1'b1, ad_en, 8'h00);
      cyc(2);
      chk("req masked", {31'h0, irq_req_a}, 32'h0);
      bus(1'b1, ad_fl, 8'h80);
      rdc("w1c other", ad_fl, 8'h40);
      bus(1'b1, ad_fl, 8'h40);
      rdc("w1c own", ad_fl, 8'h00);
      bus(1'b1, ad_st, 8'h01);
      cyc(2);
      chk("irq out clr", {31'h0, irq_out}, 32'h0);
      bus(1'b1, ad_en, 8'h40);
      auto_ack <= 1'b1;
      drv(1'b0, 1'b1);
      cyc(6);
      drv(1'b1, 1'b1);
      cyc(20);
      rdc("vector clr", ad_fl, 8'h00);
      chk("req served", {31'h0, irq_req_a}, 32'h0);
      auto_ack <= 1'b0;
      bus(1'b1, ad_st, 8'h07);
      $display("test requests done");
   endtask

   task t_level;
      drv(1'b0, 1'b1);
      cyc(6);
      drv(1'b1, 1'b1);
      cyc(6);
      bus(1'b1, ad_ctl, 8'h00);
      rdc("low mode flag", ad_fl, 8'h00);
      drv(1'b0, 1'b1);
      cyc(6);
      chk("level req", {31'h0, irq_req_a}, 32'h1);
      rdc("low flag", ad_fl, 8'h00);
      auto_ack <= 1'b1;
      cyc(20);
      chk("level retrig", {31'h0, irq_req_a}, 32'h1);
      auto_ack <= 1'b0;
      drv(1'b1, 1'b1);
      cyc(6);
      chk("level gone", {31'h0, irq_req_a}, 32'h0);
      bus(1'b1, ad_en, 8'hC0);
      drv(1'b1, 1'b0);
      cyc(6);
      chk("level req b", {31'h0, irq_req_b}, 32'h1);
      rdc("pin state low", ad_ps, 8'h01);
      drv(1'b1, 1'b1);
      cyc(6);
      chk("level gone b", {31'h0, irq_req_b}, 32'h0);
      bus(1'b1, ad_en, 8'h40);
      $display("test level done");
   endtask

   task t_wake(input logic hold);
      @(posedge core_clk);
      core_glob_en <= 1'b0;
      sleep_pd <= 1'b1;
      drv(1'b0, 1'b1);
      cyc(4);
      wd;
      cyc(3);
      chk("one sample", {31'h0, wake_req}, 32'h0);
      wd;
      cyc(2);
      chk("wake", {31'h0, wake_req}, 32'h1);
      if (!hold)
         drv(1'b1, 1'b1);
      cyc(`EIP_STARTUP_CYC + 20);
      chk("wake end", {31'h0, wake_req}, 32'h0);
      bus(1'b0, ad_st, 8'h00);
      chk("wake irq", rd & 32'h4, {29'h0, hold, 2'h0});
      sleep_pd <= 1'b0;
      drv(1'b1, 1'b1);
      bus(1'b1, ad_st, 8'h07);
      $display("test wake hold %0b done", hold);
   endtask

   initial begin
      #(8000 * 50);
      err_total++;
      $display("watchdog expired");
      results;
   end

   initial begin
      cyc(6);
      rst_b <= 1'b1;
      t_regs;
      t_edges;
      t_req;
      t_level;
      t_wake(1'b1);
      t_wake(1'b0);
      results;
   end
endmodule
